// File: src/timer_cfg.svh
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// register indices; byte address is four times the index
`define TC_IDX_CONTROL      8'h88
`define TC_IDX_MODE         8'h89
`define TC_IDX_LOW_FIRST    8'h8a
`define TC_IDX_LOW_SECOND   8'h8b
`define TC_IDX_HIGH_FIRST   8'h8c
`define TC_IDX_HIGH_SECOND  8'h8d

// timer_control field positions
`define TC_OVF_SECOND       7
`define TC_RUN_SECOND       6
`define TC_OVF_FIRST        5
`define TC_RUN_FIRST        4
`define TC_EDGE_SECOND      3
`define TC_TYPE_SECOND      2
`define TC_EDGE_FIRST       1
`define TC_TYPE_FIRST       0

// timer_mode nibble positions
`define TC_NIB_FIRST        0
`define TC_NIB_SECOND       4

// reset values
`define TC_RST_CONTROL      8'h00
`define TC_RST_MODE         8'h00
`define TC_RST_COUNT        8'h00

// oscillator periods per machine cycle; hclk is the oscillator
`define TC_OSC_PER_MC       12
`define TC_MC_LAST          4'(`TC_OSC_PER_MC - 1)

`endif

// File: src/timer_pkg.sv
package timer_pkg;

    typedef enum logic [1:0] {
        MODE_PRESCALE = 2'b00,
        MODE_CASCADE  = 2'b01,
        MODE_RELOAD   = 2'b10,
        MODE_SPLIT    = 2'b11
    } tmr_mode_e;

    // one nibble of timer_mode, high to low
    typedef struct packed {
        logic      gate;
        logic      sel;
        tmr_mode_e mode;
    } tmr_cfg_s;

    // next count bytes and the overflow they cause
    typedef struct packed {
        logic       ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } tmr_cnt_s;

    // captured ahb address phase
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [9:0] word;
    } ahb_ap_s;

endpackage

// File: src/pin_sampler.sv
`timescale 1ns/1ps
`default_nettype none

// synchronises a pin and samples it once per machine cycle
module pin_sampler (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // sample phase enable
    input  wire logic sample_en,
    // pin and results
    input  wire logic pin,
    output logic      level,
    output logic      fall
);

    logic sync1_q;
    logic sync2_q;
    logic smp_q;
    logic fall_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
        end
    end

    // high in one sample and low in the next gives one edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            smp_q  <= 1'b1;
            fall_q <= 1'b0;
        end else begin
            fall_q <= sample_en & smp_q & ~sync2_q;
            if (sample_en) begin
                smp_q  <= sync2_q;
            end
        end
    end

    assign level = smp_q;
    assign fall  = fall_q;

endmodule

`default_nettype wire

// File: src/dual_timer.sv
`timescale 1ns/1ps
`default_nettype none

`include "timer_cfg.svh"

// Summary of operation
// - timer function increments once per machine cycle of twelve oscillator periods
// - counter function samples count pin each machine cycle; high then low counts
// - edge recognition takes two machine cycles, so count rate tops at f/24
// - mode 00: high byte counts behind a 5-bit low-byte prescaler, divide by 32
// - mode 01: high and low bytes cascade into one 16-bit counter
// - mode 10: low byte counts and reloads from high byte on overflow
// - first timer mode 11: low byte own controls, high byte under second's run
// - second timer in mode 11 stops and holds its value
// - first timer split: second timer runs but never sets its overflow flag
// - second timer overflow pulses still reach the serial rate generator
// - overflow flag sets on roll to zero, or to reload value in mode 10
// - gate set: count only while run set and interrupt pin high
// - select bit clear uses machine cycles, set uses the timer's count pin
// - timer_mode bits 0-3 first timer, 4-7 second: gate, select, mode
// - overflow flags set by hardware, cleared when their vector is taken
// - run bits in timer_control are written by software to start or stop
// - falling-edge type: edge flag sets on interrupt pin edge, cleared when interrupt processed; low-level type flag follows the pin
// - type bit set selects falling edge, clear selects low level trigger
module dual_timer
    import timer_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // external pins
    input  wire logic        count_pin_first,
    input  wire logic        count_pin_second,
    input  wire logic        gate_interrupt_pin_n_first,
    input  wire logic        gate_interrupt_pin_n_second,
    // vector acknowledges from the interrupt controller
    input  wire logic        ack_overflow_first,
    input  wire logic        ack_overflow_second,
    input  wire logic        ack_ext_first,
    input  wire logic        ack_ext_second,
    // request flags and serial rate pulse
    output logic             overflow_flag_first,
    output logic             overflow_flag_second,
    output logic             ext_edge_flag_first,
    output logic             ext_edge_flag_second,
    output logic             overflow_pulse_second
);

    function automatic logic hit(input logic [9:0] word, input logic [7:0] idx);
        hit = (word == {2'b00, idx});
    endfunction

    // one step of a timer in the given mode
    function automatic tmr_cnt_s step(input tmr_mode_e mode, input logic [7:0] hi,
                                      input logic [7:0] lo, input logic tick);
        tmr_cnt_s r;
        r = '{ovf: 1'b0, hi: hi, lo: lo};
        if (tick) begin
            unique case (mode)
                MODE_PRESCALE: begin
                    r.lo[4:0] = lo[4:0] + 5'h01;
                    if (&lo[4:0]) begin
                        r.hi  = hi + 8'h01;
                        r.ovf = &hi;
                    end
                end
                MODE_CASCADE: begin
                    {r.hi, r.lo} = {hi, lo} + 16'h0001;
                    r.ovf        = &{hi, lo};
                end
                MODE_RELOAD: begin
                    r.lo  = (&lo) ? hi : lo + 8'h01;
                    r.ovf = &lo;
                end
                MODE_SPLIT: begin
                    r.lo  = lo + 8'h01;
                    r.ovf = &lo;
                end
            endcase
        end
        return r;
    endfunction

    // machine cycle divider
    logic [3:0] mc_q;
    logic       mc_tick;

    assign mc_tick = (mc_q == `TC_MC_LAST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mc_q <= 4'h0;
        end else begin
            mc_q <= mc_tick ? 4'h0 : mc_q + 4'h1;
        end
    end

    // pin sampling: 0/1 count pins, 2/3 interrupt pins
    logic [3:0] pin_vec;
    logic [3:0] lvl;
    logic [3:0] fall;

    assign pin_vec = {gate_interrupt_pin_n_second, gate_interrupt_pin_n_first,
                      count_pin_second, count_pin_first};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_smp
            pin_sampler u_smp (
                .hclk      (hclk),
                .hresetn   (hresetn),
                .sample_en (mc_tick),
                .pin       (pin_vec[gi]),
                .level     (lvl[gi]),
                .fall      (fall[gi])
            );
        end
    endgenerate

    // registers
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [7:0] mode_q;
    logic [7:0] lo0_q;
    logic [7:0] hi0_q;
    logic [7:0] lo1_q;
    logic [7:0] hi1_q;
    logic [7:0] lo0_d;
    logic [7:0] hi0_d;
    logic [7:0] lo1_d;
    logic [7:0] hi1_d;
    logic       pulse_q;

    // bus slave
    ahb_ap_s    ap_q;
    logic       rd_done_q;
    logic [31:0] rdata_q;
    logic       ap_take;
    logic [7:0] wdat;
    logic       wr_ctl;
    logic       wr_mode;
    logic       wr_lo0;
    logic       wr_hi0;
    logic       wr_lo1;
    logic       wr_hi1;
    logic [7:0] rd_mux;

    assign ap_take   = hsel & htrans[1] & hready;
    assign hreadyout = ~(ap_q.rd & ~rd_done_q);
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;
    assign wdat      = hwdata[7:0];
    assign wr_ctl    = ap_q.wr & hit(ap_q.word, `TC_IDX_CONTROL);
    assign wr_mode   = ap_q.wr & hit(ap_q.word, `TC_IDX_MODE);
    assign wr_lo0    = ap_q.wr & hit(ap_q.word, `TC_IDX_LOW_FIRST);
    assign wr_hi0    = ap_q.wr & hit(ap_q.word, `TC_IDX_HIGH_FIRST);
    assign wr_lo1    = ap_q.wr & hit(ap_q.word, `TC_IDX_LOW_SECOND);
    assign wr_hi1    = ap_q.wr & hit(ap_q.word, `TC_IDX_HIGH_SECOND);

    // unmapped words read as zero and ignore writes
    assign rd_mux = hit(ap_q.word, `TC_IDX_CONTROL)     ? ctl_q  :
                    hit(ap_q.word, `TC_IDX_MODE)        ? mode_q :
                    hit(ap_q.word, `TC_IDX_LOW_FIRST)   ? lo0_q  :
                    hit(ap_q.word, `TC_IDX_HIGH_FIRST)  ? hi0_q  :
                    hit(ap_q.word, `TC_IDX_LOW_SECOND)  ? lo1_q  :
                    hit(ap_q.word, `TC_IDX_HIGH_SECOND) ? hi1_q  : 8'h00;

    // reads wait one cycle so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q      <= '0;
            rd_done_q <= 1'b0;
            rdata_q   <= 32'h0000_0000;
        end else if (hreadyout) begin
            ap_q      <= '{wr: ap_take & hwrite, rd: ap_take & ~hwrite, word: haddr[11:2]};
            rd_done_q <= 1'b0;
        end else begin
            rd_done_q <= 1'b1;
            rdata_q   <= {24'h00_0000, rd_mux};
        end
    end

    // timer configuration
    tmr_cfg_s cfg0;
    tmr_cfg_s cfg1;
    logic     run0;
    logic     run1;
    logic     en0;
    logic     en1;
    logic     tick0;
    logic     tick1;
    logic     split0;
    logic     hi0_tick;
    logic     hi0_ovf;
    tmr_cnt_s nx0;
    tmr_cnt_s nx1;
    logic     set_ovf0;
    logic     set_ovf1;

    assign cfg0   = tmr_cfg_s'(mode_q[`TC_NIB_FIRST +: 4]);
    assign cfg1   = tmr_cfg_s'(mode_q[`TC_NIB_SECOND +: 4]);
    assign run0   = ctl_q[`TC_RUN_FIRST];
    assign run1   = ctl_q[`TC_RUN_SECOND];
    assign split0 = (cfg0.mode == MODE_SPLIT);

    // gate pins are active low interrupt inputs, counting while high
    assign en0 = run0 & (~cfg0.gate | lvl[2]);
    assign en1 = run1 & (~cfg1.gate | lvl[3]);

    // edge pulses already land one clock after the sample phase, one per machine cycle
    assign tick0 = en0 & (cfg0.sel ? fall[0] : mc_tick);
    assign tick1 = en1 & (cfg1.sel ? fall[1] : mc_tick)
                 & (cfg1.mode != MODE_SPLIT);

    // split high byte is a plain machine-cycle timer run by the second run bit
    assign hi0_tick = split0 & run1 & mc_tick;
    assign hi0_ovf  = hi0_tick & (&hi0_q);

    assign nx0 = step(cfg0.mode, hi0_q, lo0_q, tick0);
    assign nx1 = step(cfg1.mode, hi1_q, lo1_q, tick1);

    assign set_ovf0 = nx0.ovf;
    assign set_ovf1 = split0 ? hi0_ovf : nx1.ovf;

    // software writes to a count byte win over counting
    assign lo0_d = wr_lo0 ? wdat : nx0.lo;
    assign lo1_d = wr_lo1 ? wdat : nx1.lo;
    assign hi1_d = wr_hi1 ? wdat : nx1.hi;
    assign hi0_d = wr_hi0   ? wdat :
                   hi0_tick ? hi0_q + 8'h01 :
                   split0   ? hi0_q : nx0.hi;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lo0_q <= `TC_RST_COUNT;
            hi0_q <= `TC_RST_COUNT;
            lo1_q <= `TC_RST_COUNT;
            hi1_q <= `TC_RST_COUNT;
        end else begin
            lo0_q <= lo0_d;
            hi0_q <= hi0_d;
            lo1_q <= lo1_d;
            hi1_q <= hi1_d;
        end
    end

    // control register: set by hardware wins over any clear
    logic [7:0] ctl_base;

    assign ctl_base = wr_ctl ? wdat : ctl_q;

    always_comb begin
        ctl_d = ctl_base;
        ctl_d[`TC_OVF_FIRST]  = set_ovf0
                              | (ctl_base[`TC_OVF_FIRST] & ~ack_overflow_first);
        ctl_d[`TC_OVF_SECOND] = set_ovf1
                              | (ctl_base[`TC_OVF_SECOND] & ~ack_overflow_second);
        // falling-edge type latches; low-level type follows the pin
        ctl_d[`TC_EDGE_FIRST] = ctl_base[`TC_TYPE_FIRST]
                              ? (fall[2] | (ctl_base[`TC_EDGE_FIRST] & ~ack_ext_first))
                              : ~lvl[2];
        ctl_d[`TC_EDGE_SECOND] = ctl_base[`TC_TYPE_SECOND]
                               ? (fall[3] | (ctl_base[`TC_EDGE_SECOND] & ~ack_ext_second))
                               : ~lvl[3];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_q   <= `TC_RST_CONTROL;
            mode_q  <= `TC_RST_MODE;
            pulse_q <= 1'b0;
        end else begin
            ctl_q   <= ctl_d;
            pulse_q <= nx1.ovf;
            if (wr_mode) begin
                mode_q <= wdat;
            end
        end
    end

    assign overflow_flag_first   = ctl_q[`TC_OVF_FIRST];
    assign overflow_flag_second  = ctl_q[`TC_OVF_SECOND];
    assign ext_edge_flag_first   = ctl_q[`TC_EDGE_FIRST];
    assign ext_edge_flag_second  = ctl_q[`TC_EDGE_SECOND];
    assign overflow_pulse_second = pulse_q;

endmodule

`default_nettype wire

// File: verification/dual_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module dual_timer_monitor (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // acks, flags and pulse
    input wire logic        ack_overflow_first,
    input wire logic        ack_overflow_second,
    input wire logic        overflow_flag_first,
    input wire logic        overflow_flag_second,
    input wire logic        ext_edge_flag_first,
    input wire logic        overflow_pulse_second
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    wire take = hsel && htrans[1] && hready;

    a_reset_quiet: assert property (
        $rose(hresetn) |-> !overflow_flag_first && !overflow_flag_second
        && !overflow_pulse_second) else $error("flag set after reset");
    a_write_nowait: assert property (
        take && hwrite |=> hreadyout) else $error("write stalled");
    a_read_onewait: assert property (
        take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    a_resp_okay: assert property (
        hresp == 1'b0) else $error("error response");
    a_rdata_byte: assert property (
        $rose(hreadyout) |-> hrdata[31:8] == 24'h0) else $error("upper read bits set");
    // counts advance at most once a machine cycle, so pulses sit at least twelve clocks apart; eight quiet clocks are checked
    a_pulse_spacing: assert property (
        overflow_pulse_second |=> !overflow_pulse_second [*8]) else $error("pulses too close");
    // a flag drops only through its vector ack or a register write
    a_first_hold: assert property (
        (overflow_flag_first && !(take && hwrite)) ##1
        (overflow_flag_first && !ack_overflow_first) |=> overflow_flag_first)
        else $error("first flag lost");
    a_second_hold: assert property (
        (overflow_flag_second && !(take && hwrite)) ##1
        (overflow_flag_second && !ack_overflow_second) |=> overflow_flag_second)
        else $error("second flag lost");

    c_ovf_first: cover property ($rose(overflow_flag_first));
    c_pulse: cover property ($rose(overflow_pulse_second));
    c_ext_edge: cover property ($rose(ext_edge_flag_first));
endmodule

`default_nettype wire

// File: verification/ext_pins.sv
`timescale 1ns/1ps
`default_nettype none

module ext_pins (
    // clock
    input  wire logic      hclk,
    // pins
    output var logic [1:0] cnt,
    output var logic [1:0] gate_n
);
    initial begin
        cnt = 2'b11;
        gate_n = 2'b11;
    end

    // 14 clocks a level, so the once-per-machine-cycle sample cannot miss it
    task fall(input int i, input int n);
        repeat (n) begin
            cnt[i] <= 1'b0;
            repeat (14) @(posedge hclk);
            cnt[i] <= 1'b1;
            repeat (14) @(posedge hclk);
        end
    endtask

    task gate(input int i, input logic v);
        gate_n[i] <= v;
    endtask
endmodule

`default_nettype wire

// File: verification/tb_dual_timer.sv
`timescale 1ns/1ps
`default_nettype none

module tb_dual_timer;
    import timer_pkg::*;

    // byte addresses, four times the register index
    localparam logic [11:0] CA = 12'h220, MA = 12'h224, L1 = 12'h228;
    localparam logic [11:0] L2 = 12'h22c, H1 = 12'h230, H2 = 12'h234;

    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [3:0] ack = 4'h0;
    logic [1:0] cnt, gnt;
    logic [4:0] outs;
    logic [7:0] rd_last;
    int n_errors = 0, checked = 0;

    initial forever #12.5 hclk = ~hclk;

    ext_pins ext_pins_inst (.hclk(hclk), .cnt(cnt), .gate_n(gnt));

    dual_timer dual_timer_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .count_pin_first(cnt[0]), .count_pin_second(cnt[1]),
        .gate_interrupt_pin_n_first(gnt[0]), .gate_interrupt_pin_n_second(gnt[1]),
        .ack_overflow_first(ack[0]), .ack_overflow_second(ack[1]),
        .ack_ext_first(ack[2]), .ack_ext_second(ack[3]),
        .overflow_flag_first(outs[0]), .overflow_flag_second(outs[1]),
        .ext_edge_flag_first(outs[2]), .ext_edge_flag_second(outs[3]),
        .overflow_pulse_second(outs[4])
    );

    task finish_test;
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // waits on settled values at the falling edge, acts on the next rising edge
    task wait_hi(input int i, input int lim);
        int n;
        n = 0;
        do @(negedge hclk); while (outs[i] !== 1'b1 && ++n < lim);
        chk($sformatf("output %0d", i), 8'h01, {7'h0, outs[i]});
        if (outs[i] !== 1'b1) finish_test;
        @(posedge hclk);
    endtask

    task hold;
        int n;
        n = 0;
        do @(negedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
        if (hreadyout !== 1'b1) begin
            chk("hreadyout", 8'h01, {7'h0, hreadyout});
            finish_test;
        end
        rd_last = hrdata[7:0];
        @(posedge hclk);
    endtask

    task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        hold;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        hold;
    endtask

    task wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task rchk(input logic [11:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), e, rd_last);
    endtask

    task fchk(input int i, input logic e);
        @(negedge hclk);
        chk($sformatf("output %0d", i), {7'h0, e}, {7'h0, outs[i]});
        @(posedge hclk);
    endtask

    task pulse(input int i);
        ack[i] <= 1'b1;
        @(posedge hclk);
        ack[i] <= 1'b0;
        @(posedge hclk);
    endtask

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 5; i++) fchk(i, 1'b0);
        rchk(CA, 8'h00);
        rchk(MA, 8'h00);
        rchk(H2, 8'h00);
        wr(12'h200, 8'h5a);
        rchk(12'h200, 8'h00);
        wr(MA, 8'ha5);
        rchk(MA, 8'ha5);
        wr(L1, 8'hfe);
        wr(H1, 8'hff);
        wr(MA, 8'h01);
        wr(CA, 8'h10);
        repeat (10) @(posedge hclk);
        fchk(0, 1'b0);
        wait_hi(0, 20);
        pulse(0);
        fchk(0, 1'b0);
        // stop first so no count slips in while the bytes are loaded
        wr(CA, 8'h00);
        wr(L1, 8'h3f);
        wr(H1, 8'hff);
        wr(MA, 8'h00);
        wr(CA, 8'h10);
        wait_hi(0, 20);
        wr(CA, 8'h00);
        rchk(L1, 8'h20);
        rchk(H1, 8'h00);
        wr(H2, 8'hf0);
        wr(L2, 8'hff);
        wr(MA, 8'h20);
        wr(CA, 8'h40);
        wait_hi(4, 20);
        fchk(1, 1'b1);
        pulse(1);
        fchk(1, 1'b0);
        wr(CA, 8'h00);
        rchk(L2, 8'hf0);
        wr(L1, 8'h00);
        wr(L2, 8'h00);
        wr(MA, 8'h55);
        wr(CA, 8'h50);
        ext_pins_inst.fall(0, 3);
        ext_pins_inst.fall(1, 2);
        wr(CA, 8'h00);
        rchk(L1, 8'h03);
        rchk(L2, 8'h02);
        // gate low a machine cycle before the run bit, so no stale high level counts
        ext_pins_inst.gate(0, 1'b0);
        repeat (16) @(posedge hclk);
        wr(L1, 8'h00);
        wr(MA, 8'h09);
        wr(CA, 8'h10);
        repeat (60) @(posedge hclk);
        rchk(L1, 8'h00);
        ext_pins_inst.gate(0, 1'b1);
        repeat (40) @(posedge hclk);
        xfer(1'b0, L1, 8'h00);
        chk("gated count", 8'h01, {7'h0, rd_last != 8'h00});
        wr(CA, 8'h00);
        wr(MA, 8'h03);
        wr(L1, 8'h00);
        wr(H1, 8'hff);
        wr(CA, 8'h40);
        wait_hi(1, 20);
        rchk(L1, 8'h00);
        wr(MA, 8'h30);
        wr(L2, 8'h05);
        repeat (40) @(posedge hclk);
        rchk(L2, 8'h05);
        wr(CA, 8'h00);
        wr(MA, 8'h23);
        wr(H1, 8'h00);
        wr(H2, 8'hff);
        wr(L2, 8'hfe);
        wr(CA, 8'h40);
        wait_hi(4, 40);
        fchk(1, 1'b0);
        wr(CA, 8'h01);
        ext_pins_inst.gate(0, 1'b0);
        wait_hi(2, 40);
        ext_pins_inst.gate(0, 1'b1);
        repeat (30) @(posedge hclk);
        fchk(2, 1'b1);
        pulse(2);
        fchk(2, 1'b0);
        // level type on the second pin: the flag follows the pin and does not latch
        ext_pins_inst.gate(1, 1'b0);
        wait_hi(3, 40);
        ext_pins_inst.gate(1, 1'b1);
        repeat (30) @(posedge hclk);
        fchk(3, 1'b0);
        finish_test;
    end
endmodule

bind dual_timer dual_timer_monitor dual_timer_monitor_inst (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
    .ack_overflow_first, .ack_overflow_second, .overflow_flag_first,
    .overflow_flag_second, .ext_edge_flag_first, .overflow_pulse_second
);

`default_nettype wire
